// >>> hdl/pgc_top.sv
/*
  Power-good source selection and clock-output control with an
  Avalon-MM register slave.
  Assumes one 100 MHz always-on clock and synchronous status inputs.
*/
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "pgc_regs.svh"
module pgc_top
  import pgc_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     srst,
  input  wire logic [`PGC_ADDR_W-1:0]   avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  output logic      [1:0]               avs_response,
  input  wire logic                     config_load,
  input  wire logic [15:0]              config_oscillator_control,
  input  wire logic [9:0]               regulator_good,
  input  wire logic [3:0]               converter_good,
  output logic                          power_good_output,
  input  wire logic [4:0]               slot_strobe,
  input  wire logic                     startup_active,
  input  wire logic                     sleep_entry_active,
  input  wire logic [1:0]               power_state,
  input  wire logic                     on_request,
  input  wire logic                     crystal_valid,
  input  wire logic                     rc_clock,
  input  wire logic                     crystal_clock,
  output logic                          on_transition_grant,
  output logic                          crystal_osc_enable,
  output logic                          rtc_clock_enable,
  output logic                          clock_output_pin_out,
  output logic                          clock_output_pin_oe_n
);
  // ========================================================================
  // State
  typedef struct packed {
    logic [15:0] pg_src1;
    logic [15:0] pg_src2;
    logic [15:0] clk_ctrl1;
    logic [15:0] clk_ctrl2;
    logic        unlocked;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } pgc_top_state_type;

  pgc_top_state_type st;
  pgc_top_state_type next_st;

  pgc_cfg_if cfg_bus ();

  logic [15:0] idx;
  logic        lane_lo;
  logic        lane_hi;
  logic        req;
  logic        hit;
  logic [15:0] wmask;
  logic [15:0] wdata;
  logic [15:0] rsel;
  logic        gate;
  logic        use_xtal;
  logic [15:0] status_word;

  assign idx     = avs_address[`PGC_ADDR_W-1:2];
  assign lane_lo = avs_byteenable[0];
  assign lane_hi = avs_byteenable[1];
  assign req     = (avs_read || avs_write) && !st.ack;
  assign wmask   = {{8{lane_hi}}, {8{lane_lo}}};
  assign wdata   = avs_writedata[15:0];

  assign status_word = {11'h000, crystal_valid, rtc_clock_enable, crystal_osc_enable,
                        gate, power_good_output};

  // ========================================================================
  // Register file and bus slave
  always_comb begin
    next_st     = st;
    next_st.ack = req;
    hit         = 1'b1;
    rsel        = 16'h0000;
    case (idx)
      `PGC_IDX_PG_SRC1:   rsel = st.pg_src1;
      `PGC_IDX_PG_SRC2:   rsel = st.pg_src2;
      `PGC_IDX_CLK_CTRL1: rsel = st.clk_ctrl1;
      `PGC_IDX_CLK_CTRL2: rsel = st.clk_ctrl2;
      `PGC_IDX_STATUS:    rsel = status_word;
      `PGC_IDX_KEY:       rsel = {15'h0000, st.unlocked};
      default:            hit  = 1'b0;
    endcase
    if (req && avs_read) begin
      next_st.rdata = {16'h0000, rsel};
      next_st.err   = !hit;
    end
    if (req && avs_write) begin
      next_st.err = !hit;
      case (idx)
        `PGC_IDX_PG_SRC1: begin
          next_st.pg_src1 = ((st.pg_src1 & ~wmask) | (wdata & wmask)) & 16'h000F;
        end
        `PGC_IDX_PG_SRC2: begin
          next_st.pg_src2 = ((st.pg_src2 & ~wmask) | (wdata & wmask)) & 16'h03FF;
        end
        `PGC_IDX_CLK_CTRL1: begin
          next_st.clk_ctrl1 = ((st.clk_ctrl1 & ~wmask) | (wdata & wmask)) & `PGC_CTRL1_MASK;
          // Protected enable keeps its value while locked
          if (!st.unlocked) begin
            next_st.clk_ctrl1[`PGC_CLK_ENA_BIT] = st.clk_ctrl1[`PGC_CLK_ENA_BIT];
          end
        end
        `PGC_IDX_CLK_CTRL2: begin
          // Crystal enable stays as it is on software writes
          next_st.clk_ctrl2 = (st.clk_ctrl2 & ~(wmask & `PGC_CTRL2_SW_MASK)) |
                              (wdata & wmask & `PGC_CTRL2_SW_MASK);
        end
        `PGC_IDX_STATUS: begin
          // Read-only word; a write is accepted and dropped
        end
        `PGC_IDX_KEY: begin
          if (lane_lo && lane_hi) begin
            next_st.unlocked = (wdata == `PGC_KEY_VALUE);
          end
        end
        default: begin
          next_st.err = 1'b1;
        end
      endcase
    end
    // Configuration load outranks a software write in the same cycle
    if (config_load) begin
      next_st.clk_ctrl2 = config_oscillator_control & (`PGC_CTRL2_SW_MASK | 16'h2000);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st.pg_src1   <= `PGC_RST_PG_SRC1;
      st.pg_src2   <= `PGC_RST_PG_SRC2;
      st.clk_ctrl1 <= `PGC_RST_CLK_CTRL1;
      st.clk_ctrl2 <= `PGC_RST_CLK_CTRL2;
      st.unlocked  <= 1'b0;
      st.ack       <= 1'b0;
      st.err       <= 1'b0;
      st.rdata     <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // One wait state: answer on the second edge of a request
  assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
  assign avs_readdata    = st.rdata;
  assign avs_response    = st.err ? 2'h2 : 2'h0;

  // ========================================================================
  // Configuration fan-out
  assign cfg_bus.clock_output_enable     = st.clk_ctrl1[`PGC_CLK_ENA_BIT];
  assign cfg_bus.clock_output_start_slot = st.clk_ctrl1[`PGC_START_SLOT_MSB:`PGC_START_SLOT_LSB];
  assign cfg_bus.clock_output_sleep_slot = st.clk_ctrl1[`PGC_SLEEP_SLOT_MSB:`PGC_SLEEP_SLOT_LSB];
  assign cfg_bus.open_drain              = st.clk_ctrl1[`PGC_CLK_OD_BIT];
  assign cfg_bus.crystal_startup_inhibit = st.clk_ctrl2[`PGC_CRYSTAL_STARTUP_INHIBIT_BIT];
  assign cfg_bus.crystal_enable          = st.clk_ctrl2[`PGC_CRYSTAL_ENABLE_BIT];
  assign cfg_bus.backup_rtc_clock_keep   = st.clk_ctrl2[`PGC_BKUP_BIT];

  pgc_power_good u_power_good (
    .clock             (clock),
    .srst              (srst),
    .reg_good          (regulator_good),
    .reg_select        (st.pg_src2[`PGC_REG_MSB:0]),
    .conv_good         (converter_good),
    .conv_select       (st.pg_src1[`PGC_CONV_MSB:0]),
    .power_good_output (power_good_output)
  );

  pgc_clock_unit u_clock_unit (
    .clock                    (clock),
    .srst                     (srst),
    .cfg                      (cfg_bus.sink),
    .slot_strobe              (slot_strobe),
    .startup_active           (startup_active),
    .sleep_entry_active       (sleep_entry_active),
    .power_state              (power_state),
    .on_request               (on_request),
    .crystal_valid            (crystal_valid),
    .rc_clock                 (rc_clock),
    .crystal_clock            (crystal_clock),
    .clock_output_gate        (gate),
    .clock_output_use_crystal (use_xtal),
    .on_transition_grant      (on_transition_grant),
    .crystal_osc_enable       (crystal_osc_enable),
    .rtc_clock_enable         (rtc_clock_enable)
  );

  // ========================================================================
  // Clock output pin; the source clocks are gated as data
  logic src_clk;
  assign src_clk = use_xtal ? crystal_clock : rc_clock;
  // Open drain only pulls low; CMOS drives both levels
  assign clock_output_pin_out  = gate & src_clk;
  assign clock_output_pin_oe_n = !gate || (cfg_bus.open_drain && src_clk);
endmodule : pgc_top

// >>> hdl/pgc_regs.svh
/*
  Register offsets, field positions, reset values and slot codes of the
  power-good and clock-output control block.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef PGC_REGS_SVH
`define PGC_REGS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define PGC_IDX_PG_SRC1        16'h408E
`define PGC_IDX_PG_SRC2        16'h408F
`define PGC_IDX_CLK_CTRL1      16'h4090
`define PGC_IDX_CLK_CTRL2      16'h4091
`define PGC_IDX_STATUS         16'h4092
`define PGC_IDX_KEY            16'h4093
`define PGC_ADDR_W             18

// ==========================================================================
// Reset values
`define PGC_RST_PG_SRC1        16'h0007
`define PGC_RST_PG_SRC2        16'h03FF
`define PGC_RST_CLK_CTRL1      16'h0000
`define PGC_RST_CLK_CTRL2      16'h1000

// ==========================================================================
// Field positions
`define PGC_CONV_MSB           3
`define PGC_REG_MSB            9
`define PGC_CLK_ENA_BIT        15
`define PGC_CLK_OD_BIT         13
`define PGC_START_SLOT_MSB     10
`define PGC_START_SLOT_LSB     8
`define PGC_SLEEP_SLOT_MSB     6
`define PGC_SLEEP_SLOT_LSB     4
`define PGC_CRYSTAL_STARTUP_INHIBIT_BIT       15
`define PGC_CRYSTAL_ENABLE_BIT       13
`define PGC_BKUP_BIT           12
`define PGC_CTRL1_MASK         16'hA770
`define PGC_CTRL2_SW_MASK      16'h9000

// ==========================================================================
// Unlock key and slot codes
`define PGC_KEY_VALUE          16'h9716
`define PGC_SLOT_LAST          3'h5
`define PGC_SLOT_SUM           3'h6

`endif

// >>> hdl/pgc_pkg.sv
/*
  Types of the power-good and clock-output control block.
  Assumes pgc_regs.svh for numeric constants.
*/
package pgc_pkg;

  typedef enum logic [1:0] {
    PGC_PS_OFF,
    PGC_PS_ON,
    PGC_PS_SLEEP,
    PGC_PS_BACKUP
  } pgc_power_state_type;

  typedef enum logic [1:0] {
    PGC_CK_IDLE,
    PGC_CK_RUN,
    PGC_CK_SLEPT
  } pgc_clk_state_type;

endpackage : pgc_pkg

// >>> hdl/pgc_cfg_if.sv
/*
  Configuration bundle passed from the register file to the clock unit.
  Assumes one clock domain.
*/
`timescale 1ns/1ns
interface pgc_cfg_if;
  logic       clock_output_enable;
  logic [2:0] clock_output_start_slot;
  logic [2:0] clock_output_sleep_slot;
  logic       crystal_startup_inhibit;
  logic       crystal_enable;
  logic       backup_rtc_clock_keep;
  logic       open_drain;

  modport source (output clock_output_enable, clock_output_start_slot, clock_output_sleep_slot,
                  crystal_startup_inhibit, crystal_enable, backup_rtc_clock_keep, open_drain);
  modport sink   (input  clock_output_enable, clock_output_start_slot, clock_output_sleep_slot,
                  crystal_startup_inhibit, crystal_enable, backup_rtc_clock_keep, open_drain);
endinterface : pgc_cfg_if

// >>> hdl/pgc_power_good.sv
/*
  Combines selected supply status into the power-good level.
  Assumes status inputs synchronous to clock.
*/
`timescale 1ns/1ns
`include "pgc_regs.svh"
module pgc_power_good
  import pgc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [9:0]  reg_good,
  input  wire logic [9:0]  reg_select,
  input  wire logic [3:0]  conv_good,
  input  wire logic [3:0]  conv_select,
  output logic             power_good_output
);
  typedef struct packed {
    logic good;
  } pgc_pg_state_type;

  pgc_pg_state_type st;
  pgc_pg_state_type next_st;

  // Unselected supplies count as good
  always_comb begin
    next_st      = st;
    next_st.good = &(reg_good | ~reg_select) & &(conv_good | ~conv_select);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign power_good_output = st.good;
endmodule : pgc_power_good

// >>> hdl/pgc_clock_unit.sv
/*
  Clock-output gating, source choice and oscillator enables per power state.
  Assumes slot strobes are one-cycle pulses from the sequencer.
*/
`timescale 1ns/1ns
`include "pgc_regs.svh"
module pgc_clock_unit
  import pgc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  pgc_cfg_if.sink          cfg,
  input  wire logic [4:0]  slot_strobe,
  input  wire logic        startup_active,
  input  wire logic        sleep_entry_active,
  input  wire logic [1:0]  power_state,
  input  wire logic        on_request,
  input  wire logic        crystal_valid,
  input  wire logic        rc_clock,
  input  wire logic        crystal_clock,
  output logic             clock_output_gate,
  output logic             clock_output_use_crystal,
  output logic             on_transition_grant,
  output logic             crystal_osc_enable,
  output logic             rtc_clock_enable
);
  typedef struct packed {
    pgc_clk_state_type ck;
    logic              gate;
    logic              use_xtal;
    logic              grant;
    logic              xtal_en;
    logic              rtc_en;
  } pgc_ck_state_type;

  pgc_ck_state_type st;
  pgc_ck_state_type next_st;

  logic [2:0] start_idx;
  logic [2:0] sleep_idx;
  logic       start_hit;
  logic       sleep_hit;
  logic       sleep_slot_valid;

  always_comb begin
    start_idx = cfg.clock_output_start_slot - 3'h1;
    sleep_idx = `PGC_SLOT_SUM - cfg.clock_output_sleep_slot - 3'h1;
    start_hit = 1'b0;
    sleep_hit = 1'b0;
    sleep_slot_valid = (cfg.clock_output_sleep_slot != 3'h0) &&
                       (cfg.clock_output_sleep_slot <= `PGC_SLOT_LAST);
    // Code n enables in slot n
    if ((cfg.clock_output_start_slot != 3'h0) && (cfg.clock_output_start_slot <= `PGC_SLOT_LAST)) begin
      start_hit = startup_active && slot_strobe[start_idx];
    end
    // Code n disables in slot 6-n
    if (sleep_slot_valid) begin
      sleep_hit = sleep_entry_active && slot_strobe[sleep_idx];
    end
  end

  always_comb begin
    next_st = st;
    case (st.ck)
      PGC_CK_IDLE: begin
        if (start_hit) begin
          next_st.ck = PGC_CK_RUN;
        end else if (sleep_hit) begin
          next_st.ck = PGC_CK_SLEPT;
        end
      end
      PGC_CK_RUN: begin
        if (sleep_hit) begin
          next_st.ck = PGC_CK_SLEPT;
        end
      end
      PGC_CK_SLEPT: begin
        if (start_hit || power_state == PGC_PS_ON) begin
          next_st.ck = PGC_CK_RUN;
        end
      end
      default: begin
        next_st.ck = PGC_CK_IDLE;
      end
    endcase
    // Without a valid sleep slot the enable bit alone decides, except in IDLE while startup_active
    next_st.gate = cfg.clock_output_enable &&
                   ((next_st.ck == PGC_CK_RUN) || (next_st.ck == PGC_CK_IDLE && !startup_active) ||
                    (next_st.ck == PGC_CK_SLEPT && !sleep_slot_valid));
    next_st.use_xtal = crystal_valid;
    next_st.grant    = on_request && (!cfg.crystal_startup_inhibit || crystal_valid);
    next_st.xtal_en  = cfg.crystal_enable &&
                       ((power_state != PGC_PS_BACKUP) || cfg.backup_rtc_clock_keep);
    next_st.rtc_en   = (power_state != PGC_PS_BACKUP) ||
                       (cfg.crystal_enable && cfg.backup_rtc_clock_keep);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign clock_output_gate        = st.gate;
  assign clock_output_use_crystal = st.use_xtal;
  assign on_transition_grant      = st.grant;
  assign crystal_osc_enable       = st.xtal_en;
  assign rtc_clock_enable         = st.rtc_en;
endmodule : pgc_clock_unit

// >>> testbench/pgc_top_chk.sv
/*
  Port checks of pgc_top: bus handshake, response codes, grant, power good.
  Assumes one clock domain; attached by the bind at the foot.
*/
`timescale 1ns/1ns
`include "pgc_regs.svh"
module pgc_top_chk
  import pgc_pkg::*;
(
  input wire logic                   clock,
  input wire logic                   srst,
  input wire logic [`PGC_ADDR_W-1:0] avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire logic [1:0]             avs_response,
  input wire logic [9:0]             regulator_good,
  input wire logic [3:0]             converter_good,
  input wire logic                   power_good_output,
  input wire logic                   on_request,
  input wire logic                   crystal_valid,
  input wire logic                   on_transition_grant
);
  // ====================
  // Helpers
  logic req;
  logic mapped;
  assign req    = avs_read | avs_write;
  assign mapped = (avs_address[`PGC_ADDR_W-1:2] >= `PGC_IDX_PG_SRC1) && (avs_address[`PGC_ADDR_W-1:2] <= `PGC_IDX_KEY);

  default clocking dc @(posedge clock); endclocking
  default disable iff (srst);

  // ====================
  // Register bus
  wait_first_a: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("new request not held off");
  wait_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state too long");
  idle_quiet_a: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest without request");
  rdata_hold_a: assert property (!(req && avs_waitrequest) |=> $stable(avs_readdata) && $stable(avs_response))
    else $error("read data moved between requests");
  resp_code_a: assert property (req && avs_waitrequest |=> avs_response == (mapped ? 2'h0 : 2'h2))
    else $error("wrong response code");

  // ====================
  // Status outputs; two cycles allowed after reset
  grant_on_a: assert property ((on_request && crystal_valid)[*2] |=> on_transition_grant)
    else $error("grant missing with valid crystal");
  grant_off_a: assert property ((!on_request)[*2] |=> !on_transition_grant)
    else $error("grant without request");
  pg_all_a: assert property ((&regulator_good && &converter_good)[*2] |=> power_good_output)
    else $error("power good low with all supplies good");
endmodule : pgc_top_chk

bind pgc_top pgc_top_chk u_pgc_top_chk (
  .clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .regulator_good(regulator_good), .converter_good(converter_good), .power_good_output(power_good_output),
  .on_request(on_request), .crystal_valid(crystal_valid), .on_transition_grant(on_transition_grant)
);

// >>> testbench/tb_pgc_top.sv
/*
  Self-checking bench of pgc_top through its Avalon-MM slave and status pins.
  Assumes the design files and pgc_top_chk are compiled first.
*/
`timescale 1ns/1ns
`include "pgc_regs.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_pgc_top;
  logic                   clock;
  logic                   srst;
  logic [`PGC_ADDR_W-1:0] avs_address;
  logic                   avs_read;
  logic                   avs_write;
  logic [31:0]            avs_writedata;
  logic [3:0]             avs_byteenable;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic [1:0]             avs_response;
  logic                   config_load;
  logic [15:0]            config_oscillator_control;
  logic [9:0]             regulator_good;
  logic [3:0]             converter_good;
  logic                   power_good_output;
  logic [4:0]             slot_strobe;
  logic                   startup_active;
  logic                   sleep_entry_active;
  logic [1:0]             power_state;
  logic                   on_request;
  logic                   crystal_valid;
  logic                   rc_clock;
  logic                   crystal_clock;
  logic                   on_transition_grant;
  logic                   crystal_osc_enable;
  logic                   rtc_clock_enable;
  logic                   clock_output_pin_out;
  logic                   clock_output_pin_oe_n;
  logic [15:0]            rd;
  logic [1:0]             rsp;
  logic                   hit;
  int                     bad_count;
  int                     n_compared;
  int                     c;
  int                     s;
  int                     m;

  pgc_top u_pgc_top (
    .clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .config_load(config_load),
    .config_oscillator_control(config_oscillator_control), .regulator_good(regulator_good),
    .converter_good(converter_good), .power_good_output(power_good_output), .slot_strobe(slot_strobe),
    .startup_active(startup_active), .sleep_entry_active(sleep_entry_active), .power_state(power_state),
    .on_request(on_request), .crystal_valid(crystal_valid), .rc_clock(rc_clock), .crystal_clock(crystal_clock),
    .on_transition_grant(on_transition_grant), .crystal_osc_enable(crystal_osc_enable),
    .rtc_clock_enable(rtc_clock_enable), .clock_output_pin_out(clock_output_pin_out),
    .clock_output_pin_oe_n(clock_output_pin_oe_n)
  );

  // ====================
  // Tasks
  // Request held until an edge sees waitrequest low; only the watchdog ends a hang
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
    @(posedge clock);
    avs_address   <= {idx, 2'h0};
    avs_writedata <= {16'h0000, wd};
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'h0);
    rd        = avs_readdata[15:0];
    rsp       = avs_response;
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
  endtask : bus

  task automatic wr16(input logic [15:0] idx, input logic [15:0] wd);
    bus(1'h1, idx, wd);
  endtask : wr16

  task automatic rd16(input logic [15:0] idx, input logic [15:0] exp, input logic [1:0] rexp);
    bus(1'h0, idx, 16'h0000);
    `CHK(rd, exp)
    `CHK(rsp, rexp)
  endtask : rd16

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : wt

  task automatic strobe(input int n);
    @(posedge clock);
    slot_strobe <= 5'h01 << (n - 1);
    @(posedge clock);
    slot_strobe <= 5'h00;
    @(negedge clock);
  endtask : strobe

  task automatic prep(input logic [15:0] v, input logic st, input logic sl);
    @(posedge clock);
    srst               <= 1'h1;
    startup_active     <= st;
    sleep_entry_active <= 1'h0;
    repeat (2) @(posedge clock);
    srst <= 1'h0;
    wr16(`PGC_IDX_KEY, `PGC_KEY_VALUE);
    wr16(`PGC_IDX_CLK_CTRL1, 16'h8000 | v);
    @(posedge clock);
    sleep_entry_active <= sl;
    // Sleep codes act on the way into sleep, not while ON
    power_state        <= sl ? 2'h2 : 2'h1;
  endtask : prep

  task automatic cfg(input logic [15:0] v);
    @(posedge clock);
    config_oscillator_control <= v;
    config_load               <= 1'h1;
    @(posedge clock);
    config_load <= 1'h0;
  endtask : cfg

  task automatic osc_chk(input logic ena, input logic rtc);
    for (int p = 0; p < 4; p++) begin
      @(posedge clock);
      power_state <= 2'(p);
      wt(2);
      if (p < 3) `CHK(crystal_osc_enable, ena)
      else `CHK(rtc_clock_enable, rtc)
    end
  endtask : osc_chk

  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // ====================
  // Clock, watchdog, tests
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  // Whole run is under two thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    srst = 1'h1;
    avs_address = '0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = '0;
    avs_byteenable = 4'h3;
    config_load = 1'h0;
    config_oscillator_control = 16'h0000;
    regulator_good = 10'h3FF;
    converter_good = 4'hF;
    slot_strobe = 5'h00;
    startup_active = 1'h0;
    sleep_entry_active = 1'h0;
    power_state = 2'h1;
    on_request = 1'h0;
    crystal_valid = 1'h0;
    rc_clock = 1'h0;
    crystal_clock = 1'h1;
    bad_count = 0;
    n_compared = 0;
    repeat (16) @(posedge clock);
    srst <= 1'h0;
    rd16(`PGC_IDX_PG_SRC1, 16'h0007, 2'h0);
    rd16(`PGC_IDX_PG_SRC2, 16'h03FF, 2'h0);
    rd16(`PGC_IDX_CLK_CTRL1, 16'h0000, 2'h0);
    rd16(`PGC_IDX_CLK_CTRL2, 16'h1000, 2'h0);
    rd16(16'h408D, 16'h0000, 2'h2);
    rd16(16'h4094, 16'h0000, 2'h2);
    $display("test reset values done");
    wt(2);
    `CHK(power_good_output, 1'h1)
    @(posedge clock);
    converter_good <= 4'h7;
    wt(2);
    `CHK(power_good_output, 1'h1)
    @(posedge clock);
    regulator_good <= 10'h3FE;
    wt(2);
    `CHK(power_good_output, 1'h0)
    wr16(`PGC_IDX_PG_SRC2, 16'h03FE);
    wt(2);
    `CHK(power_good_output, 1'h1)
    wr16(`PGC_IDX_PG_SRC1, 16'h000F);
    wt(2);
    `CHK(power_good_output, 1'h0)
    $display("test power good done");
    wr16(`PGC_IDX_CLK_CTRL1, 16'hFFFF);
    rd16(`PGC_IDX_CLK_CTRL1, 16'h2770, 2'h0);
    wr16(`PGC_IDX_KEY, `PGC_KEY_VALUE);
    wr16(`PGC_IDX_CLK_CTRL1, 16'h8000);
    rd16(`PGC_IDX_CLK_CTRL1, 16'h8000, 2'h0);
    wt(1);
    `CHK(clock_output_pin_oe_n, 1'h0)
    `CHK(clock_output_pin_out, 1'h0)
    @(posedge clock);
    crystal_valid <= 1'h1;
    wt(3);
    `CHK(clock_output_pin_out, 1'h1)
    wr16(`PGC_IDX_CLK_CTRL2, 16'hFFFF);
    rd16(`PGC_IDX_CLK_CTRL2, 16'h9000, 2'h0);
    on_request    <= 1'h1;
    crystal_valid <= 1'h0;
    wt(3);
    `CHK(on_transition_grant, 1'h0)
    @(posedge clock);
    crystal_valid <= 1'h1;
    wt(3);
    `CHK(on_transition_grant, 1'h1)
    @(posedge clock);
    on_request <= 1'h0;
    $display("test lock and source done");
    // Every start code, then every sleep code, against strobes 1 to 5
    for (m = 0; m < 2; m++) begin
      for (c = 0; c < 8; c++) begin
        prep((m == 1) ? 16'(c << 4) : 16'(c << 8), m == 0, m == 1);
        for (s = 1; s < 6; s++) begin
          strobe(s);
          hit = (c >= 1 && c <= 5 && s >= ((m == 1) ? 6 - c : c));
          `CHK(clock_output_pin_oe_n, (hit == (m == 1)) ? 1'h1 : 1'h0)
        end
      end
    end
    $display("test slots done");
    osc_chk(1'h0, 1'h0);
    cfg(16'h2000);
    rd16(`PGC_IDX_CLK_CTRL2, 16'h2000, 2'h0);
    osc_chk(1'h1, 1'h0);
    cfg(16'h3000);
    osc_chk(1'h1, 1'h1);
    wr16(`PGC_IDX_CLK_CTRL2, 16'h0000);
    rd16(`PGC_IDX_CLK_CTRL2, 16'h2000, 2'h0);
    $display("test oscillator done");
    close_out();
  end
endmodule : tb_pgc_top
